// File: design/tcrx_regs_top.sv
// serial slave and control register bank of the transceiver core and rx path
`timescale 1ns/1ns
`include "tcrx_defines.svh"
module tcrx_regs_top (
  input wire logic CLK, // system clock, 25 MHz
  input wire logic RST_N, // synchronous reset, active low
  input wire logic SCK, // serial clock pin from the host
  input wire logic SDA, // serial data pin level
  output logic SDA_VAL, // serial data drive value, always low
  output logic SDA_OEN, // low while pulling the data pin low
  input wire logic [9:0] ADC_RESULT, // monitor converter result
  input wire logic TX_RECOVERY_BYPASS, // transmit recovery bypass setting
  input wire logic FAULT_IN, // laser fault detector pin
  input wire logic PD_MON_TRIP, // photodiode monitor pin trip
  output logic NVM_RESET, // one-cycle reset pulse to storage
  output logic CHIP_EN, // chip enabled
  output logic PD_TRIG_EN, // monitor pin fault trigger enabled
  output logic [1:0] PD_RANGE, // photodiode range code
  output logic [11:0] PD_FULL_SCALE, // full scale in microamps
  output logic OPEN_LOOP_EN, // open-loop bias control
  output logic FAULT_DETECT_EN, // fault detection on
  output logic LASER_BIAS_EN, // bias current flowing
  output logic BIAS_SINK_SEL, // bias pin sinks current
  output logic PD_CATHODE_SEL, // photodiode cathode at supply
  output logic LASER_FAULT, // latched laser fault
  output logic OPTICAL_LOOPBACK_SEL, // transmit recovery to receive output
  output logic ELECTRICAL_LOOPBACK_SEL, // receive recovery to transmit output
  output logic MON_CONV_EN, // monitor converter enabled
  output logic MON_OSC_EN, // converter oscillator enabled
  output logic MON_CONV_RESET, // converter held in reset
  output logic [2:0] MON_INPUT_SEL, // converter input select
  output logic MON_SEL_RESERVED, // reserved select code in use
  output tcrx_pkg::tcrx_rx_s RX_CTRL // receive path controls
);
  import tcrx_pkg::*;

  localparam tcrx_bank_s BANK_RST = '{
    chip: `TCRX_RST_CHIP, bias: `TCRX_RST_BIAS, loop: `TCRX_RST_LOOP,
    mon: `TCRX_RST_MON, rxp: `TCRX_RST_RXP};

  tcrx_pins_s pins_raw;
  tcrx_pins_s pins_s;
  logic sck_d_ff;
  logic sda_d_ff;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  tcrx_state_e st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic rnw_ff;
  logic [7:0] radr_ff;
  logic wr_go;
  tcrx_bank_s bank_ff;
  logic fault_ff;
  logic bias_d_ff;
  logic fault_set;
  logic fault_clr;

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input tcrx_bank_s b,
                                         input logic [9:0] adc);
    logic [7:0] r;
    r = 8'h00;
    if (a == `TCRX_OFS_CHIP) begin
      r = b.chip;
    end else if (a == `TCRX_OFS_BIAS) begin
      r = b.bias;
    end else if (a == `TCRX_OFS_LOOP) begin
      r = b.loop;
    end else if (a == `TCRX_OFS_MON) begin
      r = b.mon;
    end else if (a == `TCRX_OFS_RXP) begin
      r = b.rxp;
    end else if (a == `TCRX_OFS_ADC_HI) begin
      r = adc[9:2];
    end else if (a == `TCRX_OFS_ADC_LO) begin
      r = {6'h00, adc[1:0]};
    end
    return r;
  endfunction : rd_byte

  function automatic logic [11:0] pd_fs(input logic [1:0] rng);
    logic [11:0] f;
    f = `TCRX_FS_LO;
    if (rng[1]) begin
      f = `TCRX_FS_HI;
    end else if (rng[0]) begin
      f = `TCRX_FS_MID;
    end
    return f;
  endfunction : pd_fs

  assign pins_raw = '{sck: SCK, sda: SDA, fault: FAULT_IN, trip: PD_MON_TRIP};

  tcrx_sync u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .pins_async(pins_raw),
    .pins_sync(pins_s)
  );

  // serial clock runs 8x slower than CLK, so edges are found by sampling
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sck_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= pins_s.sck;
      sda_d_ff <= pins_s.sda;
    end
  end

  assign rise = pins_s.sck & ~sck_d_ff;
  assign fall = ~pins_s.sck & sck_d_ff;
  assign start_ev = pins_s.sck & sck_d_ff & sda_d_ff & ~pins_s.sda;
  assign stop_ev = pins_s.sck & sck_d_ff & ~sda_d_ff & pins_s.sda;
  assign wr_go = fall && (st_ff == ST_WDATA) && (cnt_ff == `TCRX_BYTE_BITS);

  // data bits taken on the rising edge, our drive changes on the falling edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rnw_ff <= 1'b0;
      radr_ff <= 8'h00;
      SDA_OEN <= 1'b1;
      SDA_VAL <= 1'b0;
    end else begin
      SDA_VAL <= 1'b0;
      if (start_ev) begin
        // repeated start is taken the same way as a first start
        st_ff <= ST_ADDR;
        cnt_ff <= 4'h0;
        SDA_OEN <= 1'b1;
      end else if (stop_ev) begin
        st_ff <= ST_IDLE;
        SDA_OEN <= 1'b1;
      end else if (rise) begin
        if (st_ff inside {ST_ADDR, ST_REG, ST_WDATA} && cnt_ff != `TCRX_BYTE_BITS) begin
          sh_ff <= {sh_ff[6:0], pins_s.sda};
          cnt_ff <= cnt_ff + 4'h1;
        end else if (st_ff == ST_RDATA) begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end else if (fall) begin
        case (st_ff)
          ST_ADDR: begin
            if (cnt_ff == `TCRX_BYTE_BITS) begin
              cnt_ff <= 4'h0;
              if (sh_ff[7:1] == `TCRX_SLAVE_ADDR) begin
                rnw_ff <= sh_ff[0];
                SDA_OEN <= 1'b0;
                st_ff <= ST_ADDR_ACK;
              end else begin
                // not ours: leave the line high and sit out the frame
                st_ff <= ST_WAIT;
              end
            end
          end
          ST_ADDR_ACK: begin
            SDA_OEN <= 1'b1;
            st_ff <= ST_REG;
          end
          ST_REG: begin
            if (cnt_ff == `TCRX_BYTE_BITS) begin
              cnt_ff <= 4'h0;
              radr_ff <= sh_ff;
              SDA_OEN <= 1'b0;
              st_ff <= ST_REG_ACK;
            end
          end
          ST_REG_ACK: begin
            if (rnw_ff) begin
              sh_ff <= rd_byte(radr_ff, bank_ff, ADC_RESULT);
              SDA_OEN <= rd_byte(radr_ff, bank_ff, ADC_RESULT) >> 7 != 8'h00;
              st_ff <= ST_RDATA;
            end else begin
              SDA_OEN <= 1'b1;
              st_ff <= ST_WDATA;
            end
          end
          ST_WDATA: begin
            if (cnt_ff == `TCRX_BYTE_BITS) begin
              cnt_ff <= 4'h0;
              SDA_OEN <= 1'b0;
              st_ff <= ST_WDATA_ACK;
            end
          end
          ST_WDATA_ACK: begin
            SDA_OEN <= 1'b1;
            st_ff <= ST_WAIT;
          end
          ST_RDATA: begin
            if (cnt_ff == `TCRX_BYTE_BITS) begin
              cnt_ff <= 4'h0;
              SDA_OEN <= 1'b1;
              st_ff <= ST_RDATA_ACK;
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              SDA_OEN <= sh_ff[6];
            end
          end
          ST_RDATA_ACK: begin
            // one byte per frame, so the host's ack is not looked at
            st_ff <= ST_WAIT;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // reset bits are never stored, so they read zero at once
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bank_ff <= BANK_RST;
      NVM_RESET <= 1'b0;
    end else begin
      NVM_RESET <= 1'b0;
      if (wr_go) begin
        if (radr_ff == `TCRX_OFS_CHIP) begin
          if (sh_ff[`TCRX_B_GRST] || sh_ff[`TCRX_B_IFRST]) begin
            bank_ff <= BANK_RST;
            NVM_RESET <= sh_ff[`TCRX_B_GRST];
          end else begin
            bank_ff.chip <= sh_ff & ~`TCRX_SC_MASK;
          end
        end else if (radr_ff == `TCRX_OFS_BIAS) begin
          bank_ff.bias <= sh_ff;
        end else if (radr_ff == `TCRX_OFS_LOOP) begin
          bank_ff.loop <= sh_ff;
        end else if (radr_ff == `TCRX_OFS_MON) begin
          bank_ff.mon <= sh_ff;
        end else if (radr_ff == `TCRX_OFS_RXP) begin
          bank_ff.rxp <= sh_ff;
        end
      end
    end
  end

  // fault latch: only the host dropping the bias enable clears it
  assign fault_set = bank_ff.bias[`TCRX_B_BIASEN] &&
                     ((bank_ff.bias[`TCRX_B_FLTEN] && pins_s.fault) ||
                      (bank_ff.bias[`TCRX_B_PDTRIG] && pins_s.trip));
  assign fault_clr = bias_d_ff && !bank_ff.bias[`TCRX_B_BIASEN];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fault_ff <= 1'b0;
      bias_d_ff <= 1'b0;
    end else begin
      bias_d_ff <= bank_ff.bias[`TCRX_B_BIASEN];
      if (fault_set) begin
        fault_ff <= 1'b1;
      end else if (fault_clr) begin
        fault_ff <= 1'b0;
      end
    end
  end

  // all controls leave through flops, one clock behind the bank, the fault latch (LASER_FAULT, LASER_BIAS_EN) or TX_RECOVERY_BYPASS
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CHIP_EN <= 1'b1;
      PD_TRIG_EN <= 1'b0;
      PD_RANGE <= 2'h0;
      PD_FULL_SCALE <= `TCRX_FS_LO;
      OPEN_LOOP_EN <= 1'b0;
      FAULT_DETECT_EN <= 1'b0;
      LASER_BIAS_EN <= 1'b0;
      BIAS_SINK_SEL <= 1'b0;
      PD_CATHODE_SEL <= 1'b0;
      LASER_FAULT <= 1'b0;
      OPTICAL_LOOPBACK_SEL <= 1'b0;
      ELECTRICAL_LOOPBACK_SEL <= 1'b0;
      MON_CONV_EN <= 1'b0;
      MON_OSC_EN <= 1'b0;
      MON_CONV_RESET <= 1'b0;
      MON_INPUT_SEL <= 3'h0;
      MON_SEL_RESERVED <= 1'b0;
      RX_CTRL <= '0;
    end else begin
      CHIP_EN <= bank_ff.chip[`TCRX_B_CHIPEN];
      PD_TRIG_EN <= bank_ff.bias[`TCRX_B_PDTRIG];
      PD_RANGE <= bank_ff.bias[`TCRX_B_PDRNG_HI:`TCRX_B_PDRNG_LO];
      PD_FULL_SCALE <= pd_fs(bank_ff.bias[`TCRX_B_PDRNG_HI:`TCRX_B_PDRNG_LO]);
      OPEN_LOOP_EN <= bank_ff.bias[`TCRX_B_OPENLP];
      FAULT_DETECT_EN <= bank_ff.bias[`TCRX_B_FLTEN];
      LASER_BIAS_EN <= bank_ff.bias[`TCRX_B_BIASEN] && bank_ff.chip[`TCRX_B_CHIPEN] &&
                       !fault_ff;
      BIAS_SINK_SEL <= bank_ff.bias[`TCRX_B_SINK];
      PD_CATHODE_SEL <= bank_ff.bias[`TCRX_B_CATH];
      LASER_FAULT <= fault_ff;
      OPTICAL_LOOPBACK_SEL <= bank_ff.loop[`TCRX_B_OPTLB];
      ELECTRICAL_LOOPBACK_SEL <= bank_ff.loop[`TCRX_B_ELELB];
      MON_CONV_EN <= bank_ff.mon[`TCRX_B_CONVEN];
      MON_OSC_EN <= bank_ff.mon[`TCRX_B_MONITOR_OSC_EN];
      MON_CONV_RESET <= bank_ff.mon[`TCRX_B_CONVRST];
      MON_INPUT_SEL <= bank_ff.mon[`TCRX_B_MONSEL_HI:`TCRX_B_MONSEL_LO];
      MON_SEL_RESERVED <= bank_ff.mon[`TCRX_B_MONSEL_HI];
      RX_CTRL.power_down <= bank_ff.rxp[`TCRX_B_RXPD];
      RX_CTRL.driver_off <= bank_ff.rxp[`TCRX_B_DRVOFF];
      RX_CTRL.invert <= bank_ff.rxp[`TCRX_B_INV];
      RX_CTRL.recovery_off <= bank_ff.rxp[`TCRX_B_RECOFF];
      RX_CTRL.recovery_bypass <= bank_ff.rxp[`TCRX_B_RECBP] && TX_RECOVERY_BYPASS;
      RX_CTRL.offset_cancel_off <= bank_ff.rxp[`TCRX_B_OCOFF];
      RX_CTRL.equaliser_off <= bank_ff.rxp[`TCRX_B_EQOFF];
      RX_CTRL.loss_range_sel <= bank_ff.rxp[`TCRX_B_LOSRNG];
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  global_reset_a: assert property (
    wr_go && radr_ff == `TCRX_OFS_CHIP && sh_ff[`TCRX_B_GRST]
      |=> bank_ff == BANK_RST && NVM_RESET ##1 !NVM_RESET)
    else $error("global reset did not restore defaults");

  iface_reset_a: assert property (
    wr_go && radr_ff == `TCRX_OFS_CHIP && sh_ff[`TCRX_B_IFRST]
      |=> bank_ff == BANK_RST ##1 CHIP_EN)
    else $error("interface reset did not restore defaults");

  chip_en_rst_a: assert property (
    $rose(RST_N) |-> CHIP_EN && !LASER_BIAS_EN)
    else $error("chip enable not set after reset");

  self_clear_a: assert property (
    wr_go && radr_ff == `TCRX_OFS_CHIP
      |=> (bank_ff.chip & `TCRX_SC_MASK) == 8'h00)
    else $error("self-clearing bit held");

  fault_latch_a: assert property (
    fault_set |=> fault_ff ##1 LASER_FAULT && !LASER_BIAS_EN)
    else $error("fault not latched");

  fault_clear_a: assert property (
    $fell(bank_ff.bias[`TCRX_B_BIASEN]) |=> !fault_ff ##1 !LASER_FAULT)
    else $error("fault not cleared by bias disable");

  pd_range_a: assert property (
    PD_RANGE == 2'h1 |-> PD_FULL_SCALE == `TCRX_FS_MID)
    else $error("wrong full scale for range");

  rx_bypass_a: assert property (
    RX_CTRL.recovery_bypass |-> $past(TX_RECOVERY_BYPASS) &&
      $past(bank_ff.rxp[`TCRX_B_RECBP]))
    else $error("rx bypass without tx bypass");

  addr_ack_a: assert property (
    st_ff == ST_ADDR_ACK && !SDA_OEN |-> sh_ff[7:1] == `TCRX_SLAVE_ADDR)
    else $error("acked a foreign address");

  adc_high_a: assert property (
    fall && st_ff == ST_REG_ACK && rnw_ff && radr_ff == `TCRX_OFS_ADC_HI
      |=> sh_ff == $past(ADC_RESULT[9:2]) && st_ff == ST_RDATA)
    else $error("converter high byte not loaded");

  reserved_rw_a: assert property (
    wr_go && radr_ff == `TCRX_OFS_LOOP |=> bank_ff.loop == $past(sh_ff))
    else $error("reserved bits not stored");
endmodule : tcrx_regs_top

// File: design/tcrx_sync.sv
// two-flop synchronisers for the pins that arrive from outside the clock
`timescale 1ns/1ns
module tcrx_sync (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [3:0] pins_async, // raw pin levels
  output logic [3:0] pins_sync // synchronised levels
);
  logic [3:0] meta_ff;
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_ff[i] <= 1'b1;
          pins_sync[i] <= 1'b1;
        end else begin
          meta_ff[i] <= pins_async[i];
          pins_sync[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
endmodule : tcrx_sync

// File: dv/tb_transceiver_core_rx_control_regs.sv
// self-checking bench: serial register traffic and control outputs
`timescale 1ns/1ns
`include "tcrx_defines.svh"
module tb_transceiver_core_rx_control_regs;
  import tcrx_pkg::*;
  logic clk, rst_n, tx_byp, fault_in, pd_trip, sck, sda_drv, sda_wire, sda_o, sda_oen;
  logic res_valid, nvm_reset, chip_en, pd_trig_en, open_loop, fdet, bias_en, sink, cath;
  logic fault, optlb, elelb, conv_en, osc_en, conv_rst, mon_res;
  logic [9:0] adc;
  logic [7:0] res_data;
  logic [1:0] pd_range;
  logic [2:0] mon_sel;
  logic [11:0] pd_fs;
  tcrx_rx_s rx;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic [31:0] seed = 32'he27e192d;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int nvm_cnt = 0;
  // open-drain wire with pull-up
  assign sda_wire = sda_drv & (sda_oen ? 1'b1 : sda_o);
  tcrx_regs_top dut (.CLK(clk), .RST_N(rst_n), .SCK(sck), .SDA(sda_wire), .SDA_VAL(sda_o),
    .SDA_OEN(sda_oen), .ADC_RESULT(adc), .TX_RECOVERY_BYPASS(tx_byp), .FAULT_IN(fault_in),
    .PD_MON_TRIP(pd_trip), .NVM_RESET(nvm_reset), .CHIP_EN(chip_en), .PD_TRIG_EN(pd_trig_en),
    .PD_RANGE(pd_range), .PD_FULL_SCALE(pd_fs), .OPEN_LOOP_EN(open_loop),
    .FAULT_DETECT_EN(fdet), .LASER_BIAS_EN(bias_en), .BIAS_SINK_SEL(sink),
    .PD_CATHODE_SEL(cath), .LASER_FAULT(fault), .OPTICAL_LOOPBACK_SEL(optlb),
    .ELECTRICAL_LOOPBACK_SEL(elelb), .MON_CONV_EN(conv_en), .MON_OSC_EN(osc_en),
    .MON_CONV_RESET(conv_rst), .MON_INPUT_SEL(mon_sel), .MON_SEL_RESERVED(mon_res),
    .RX_CTRL(rx));
  tcrx_host_model host (.clk(clk), .sda_wire(sda_wire), .sck(sck), .sda_drv(sda_drv),
    .res_valid(res_valid), .res_data(res_data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] view(input int r);
    case (r)
      1: return {pd_trig_en, pd_range, open_loop, fdet, bias_en, sink, cath};
      2: return {6'h00, optlb, elelb};
      3: return {conv_en, osc_en, 1'b0, conv_rst, 1'b0, mon_sel};
      default: return rx;
    endcase
  endfunction : view
  function automatic logic [7:0] want(input int r, input logic [7:0] v);
    case (r)
      2: return v & 8'h03;
      3: return v & 8'hd7;
      4: return {v[7:4], v[3] & tx_byp, v[2:0]};
      default: return v;
    endcase
  endfunction : want
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic note(input string n, input logic [7:0] v);
    name_q.push_back(n);
    exp_q.push_back(v);
  endtask : note
  task automatic wr(input logic [7:0] ra, input logic [7:0] v);
    note("write ack", 8'h00);
    host.frame(`TCRX_SLAVE_ADDR, 1'b0, ra, v);
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    note("read ack", 8'h00);
    note($sformatf("reg %h", ra), e);
    host.frame(`TCRX_SLAVE_ADDR, 1'b1, ra, 8'h00);
  endtask : rd
  task automatic wv(input int r, input logic [7:0] v);
    wr(8'(r), v);
    rd(8'(r), v);
    chk("outputs", 12'(want(r, v)), 12'(view(r)));
  endtask : wv
  task automatic pulse(input logic trip);
    @(posedge clk);
    pd_trip <= trip;
    fault_in <= !trip;
    repeat (4) @(posedge clk);
    pd_trip <= 1'b0;
    fault_in <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse
  // results are matched in arrival order against the notes
  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("extra result", 12'hfff, 12'(res_data));
      else
        chk(name_q.pop_front(), 12'(exp_q.pop_front()), 12'(res_data));
    end
    if (nvm_reset === 1'b1)
      nvm_cnt++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    logic [7:0] v;
    logic [31:0] a;
    int n;
    rst_n = 1'b0;
    tx_byp = 1'b0;
    fault_in = 1'b0;
    pd_trip = 1'b0;
    adc = 10'h000;
    // synchronisers reset to the idle-high pin level, so two edges suffice
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("chip enable", 12'h001, 12'(chip_en));
    chk("full scale", `TCRX_FS_LO, pd_fs);
    rd(8'h00, `TCRX_RST_CHIP);
    for (int r = 1; r < 5; r++) rd(8'(r), 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'(rnd());
      v[6:5] = 2'(i);
      v[2] = 1'b1;
      wv(1, v);
      chk("full scale", i[1] ? `TCRX_FS_HI : i[0] ? `TCRX_FS_MID : `TCRX_FS_LO, pd_fs);
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'(rnd());
      v[2:0] = 3'(i);
      wv(3, v);
      chk("reserved select", 12'(i > 3), 12'(mon_res));
    end
    wv(2, 8'(rnd()));
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      tx_byp <= 1'(i);
      wv(4, 8'(rnd()) | 8'h08);
    end
    a = rnd();
    @(posedge clk);
    adc <= a[9:0];
    rd(`TCRX_OFS_ADC_HI, a[9:2]);
    rd(`TCRX_OFS_ADC_LO, {6'h00, a[1:0]});
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wv(2, 8'h5a);
    note("foreign ack", 8'h07);
    host.frame(7'h09, 1'b0, 8'h02, 8'ha5);
    rd(8'h02, 8'h5a);
    wv(1, 8'h0c);
    pulse(1'b0);
    chk("fault", 12'h001, 12'(fault));
    chk("bias on", 12'h000, 12'(bias_en));
    wr(8'h01, 8'h08);
    chk("fault", 12'h000, 12'(fault));
    wv(1, 8'h84);
    pulse(1'b1);
    chk("fault", 12'h001, 12'(fault));
    wr(8'h01, 8'h80);
    chk("fault", 12'h000, 12'(fault));
    wv(1, 8'h04);
    pulse(1'b0);
    pulse(1'b1);
    chk("fault", 12'h000, 12'(fault));
    wr(8'h00, 8'h40);
    chk("chip enable", 12'h000, 12'(chip_en));
    rd(8'h00, 8'h40);
    wr(8'h00, 8'h02);
    rd(8'h00, `TCRX_RST_CHIP);
    rd(8'h01, 8'h00);
    chk("chip enable", 12'h001, 12'(chip_en));
    wr(8'h03, 8'hff);
    n = nvm_cnt;
    wr(8'h00, 8'h80);
    chk("storage reset", 12'(n + 1), 12'(nvm_cnt));
    rd(8'h00, `TCRX_RST_CHIP);
    rd(8'h03, 8'h00);
    repeat (20) @(posedge clk);
    chk("pending", 12'h000, 12'(exp_q.size()));
    close_out();
  end
endmodule : tb_transceiver_core_rx_control_regs

// File: dv/tcrx_host_model.sv
// two-wire host model: frames, byte shifting and ack sampling
`timescale 1ns/1ns
module tcrx_host_model (
  input wire logic clk, // system clock
  input wire logic sda_wire, // resolved data line
  output logic sck, // serial clock, idles high
  output logic sda_drv, // low pulls data down, high releases
  output logic res_valid, // one-cycle result strobe
  output logic [7:0] res_data // ack summary or read byte
);
  initial begin
    sck = 1'b1;
    sda_drv = 1'b1;
    res_valid = 1'b0;
    res_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // data moves mid-low so it never looks like a start or stop
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_drv <= b;
    tick(2);
    sck <= 1'b1;
    tick(4);
    s = sda_wire;
    sck <= 1'b0;
  endtask : bit_io
  task automatic byte_out(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, a);
  endtask : byte_out
  // host ack is left high: one byte per frame, device ignores it
  task automatic byte_in(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask : byte_in
  task automatic start_c;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    sck <= 1'b0;
  endtask : start_c
  task automatic stop_c;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    sck <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask : stop_c
  task automatic report(input logic [7:0] v);
    res_data <= v;
    res_valid <= 1'b1;
    tick(1);
    res_valid <= 1'b0;
    // spare edge so a following report never rewrites the strobe in one step
    tick(1);
  endtask : report
  task automatic frame(input logic [6:0] dev, input logic rd, input logic [7:0] ra,
                       input logic [7:0] wd);
    logic a0;
    logic a1;
    logic a2;
    logic [7:0] d;
    start_c();
    byte_out({dev, rd}, a0);
    byte_out(ra, a1);
    a2 = 1'b0;
    d = 8'h00;
    if (rd) begin
      byte_in(d);
    end else begin
      byte_out(wd, a2);
    end
    stop_c();
    report({5'h00, a0, a1, a2});
    if (rd) begin
      report(d);
    end
  endtask : frame
endmodule : tcrx_host_model

// File: shared/tcrx_defines.svh
// offsets, field positions, reset values and counts of the control bank
`ifndef TCRX_DEFINES_SVH
`define TCRX_DEFINES_SVH
`define TCRX_SLAVE_ADDR 7'h08
`define TCRX_BYTE_BITS 4'h8
`define TCRX_OFS_CHIP 8'h00
`define TCRX_OFS_BIAS 8'h01
`define TCRX_OFS_LOOP 8'h02
`define TCRX_OFS_MON 8'h03
`define TCRX_OFS_RXP 8'h04
`define TCRX_OFS_ADC_HI 8'h28
`define TCRX_OFS_ADC_LO 8'h29
`define TCRX_RST_CHIP 8'h41
`define TCRX_RST_BIAS 8'h00
`define TCRX_RST_LOOP 8'h00
`define TCRX_RST_MON 8'h00
`define TCRX_RST_RXP 8'h00
`define TCRX_SC_MASK 8'h82
`define TCRX_B_GRST 7
`define TCRX_B_IFRST 1
`define TCRX_B_CHIPEN 0
`define TCRX_B_PDTRIG 7
`define TCRX_B_PDRNG_HI 6
`define TCRX_B_PDRNG_LO 5
`define TCRX_B_OPENLP 4
`define TCRX_B_FLTEN 3
`define TCRX_B_BIASEN 2
`define TCRX_B_SINK 1
`define TCRX_B_CATH 0
`define TCRX_B_OPTLB 1
`define TCRX_B_ELELB 0
`define TCRX_B_CONVEN 7
`define TCRX_B_MONITOR_OSC_EN 6
`define TCRX_B_CONVRST 4
`define TCRX_B_MONSEL_HI 2
`define TCRX_B_MONSEL_LO 0
`define TCRX_B_RXPD 7
`define TCRX_B_DRVOFF 6
`define TCRX_B_INV 5
`define TCRX_B_RECOFF 4
`define TCRX_B_RECBP 3
`define TCRX_B_OCOFF 2
`define TCRX_B_EQOFF 1
`define TCRX_B_LOSRNG 0
// full-scale photodiode range in microamps: 3080, 1540, 770
`define TCRX_FS_HI 12'hc08
`define TCRX_FS_MID 12'h604
`define TCRX_FS_LO 12'h302
`endif

// File: shared/tcrx_pkg.sv
// types shared by the control bank and its serial engine
package tcrx_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_WAIT
  } tcrx_state_e;
  typedef struct packed {
    logic [7:0] chip;
    logic [7:0] bias;
    logic [7:0] loop;
    logic [7:0] mon;
    logic [7:0] rxp;
  } tcrx_bank_s;
  typedef struct packed {
    logic sck;
    logic sda;
    logic fault;
    logic trip;
  } tcrx_pins_s;
  typedef struct packed {
    logic power_down;
    logic driver_off;
    logic invert;
    logic recovery_off;
    logic recovery_bypass;
    logic offset_cancel_off;
    logic equaliser_off;
    logic loss_range_sel;
  } tcrx_rx_s;
endpackage : tcrx_pkg
